// >>> design/ext_port_pins.sv
`timescale 1ns/1ns
`include "ext_port_map.svh"
// Notes on behaviour
// - Every external access drives its address on the 24-bit address bus.
// - Each data pin serves memory, parallel input, flag or pulse-width use by configuration.
// - After reset data pins 4-31 are memory mode; flag pins 0-3 flag mode.
// - When enabled, input channel 0 samples the data pins as parallel input.
// - Low acknowledge holds off completion of the current access.
// - Read strobe goes low for each word read.
// - Write strobe goes low for each word written.
// - SDRAM operation is encoded on row, column and write strobes together.
// - Active-low bank selects decode from address, change with address lines.
// - Dedicated bit-ten line replaces address bit 10 only during SDRAM accesses.
module ext_port_pins
#(
  parameter int STROBE_CYC = `EP_STROBE_CYC
)
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Core access request
  input  wire logic                      accReq,
  input  wire logic                      accWrite,
  input  wire logic [`EP_ADDR_W-1:0]     accAddr,
  input  wire logic [`EP_DATA_W-1:0]     accWdata,
  output logic                           accReady,
  output logic                           accDone,
  output logic [`EP_DATA_W-1:0]          accRdata,
  // SDRAM command request
  input  wire ext_port_pkg::sdram_cmd_t  sdCmd,
  input  wire logic                      sdCmdValid,
  input  wire logic                      sdTenValue,
  // Pin configuration
  input  wire logic [2*`EP_DATA_W-1:0]   pinModeCfg,
  input  wire logic                      pinModeLoad,
  input  wire logic                      parallel_input_control,
  input  wire logic [`EP_DATA_W-1:0]     flagOut,
  input  wire logic [`EP_DATA_W-1:0]     flagOe,
  input  wire logic [`EP_DATA_W-1:0]     pwmOut,
  output logic [`EP_DATA_W-1:0]          flagIn,
  output logic [`EP_DATA_W-1:0]          parallel_data_input,
  output logic                           parallelValid,
  // Pins
  output logic [`EP_ADDR_W-1:0]          addrPins,
  input  wire logic [`EP_DATA_W-1:0]     dataIn,
  output logic [`EP_DATA_W-1:0]          dataOut,
  output logic [`EP_DATA_W-1:0]          dataOeN,
  input  wire logic                      ackIn,
  output logic                           readStrobeN,
  output logic                           writeStrobeN,
  output logic [`EP_BANKS-1:0]           bank_select_n,
  output logic                           sdram_bit_ten_line,
  output logic                           sdram_row_strobe_n,
  output logic                           sdram_column_strobe_n,
  output logic                           sdram_write_strobe_n
);
  import ext_port_pkg::*;

  // Strobe counter is 8 bits wide
  if (STROBE_CYC < 1 || STROBE_CYC > 255)
  begin : badStrobeCyc
    $error("STROBE_CYC out of range");
  end

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  logic [`EP_DATA_W-1:0] dataMeta_r;
  logic [`EP_DATA_W-1:0] dataSync_r;
  logic                  ackMeta_r;
  logic                  ackSync_r;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dataMeta_r <= '0;
      dataSync_r <= '0;
      ackMeta_r  <= 1'b1;
      ackSync_r  <= 1'b1;
    end
    else
    begin
      dataMeta_r <= dataIn;
      dataSync_r <= dataMeta_r;
      ackMeta_r  <= ackIn;
      ackSync_r  <= ackMeta_r;
    end
  end

  // ****************************************
  // Per-pin mode
  // ****************************************
  function automatic logic [1:0] modeOf(input logic [2*`EP_DATA_W-1:0] cfg, input int idx);
    modeOf = cfg[2*idx +: 2];
  endfunction

  logic [2*`EP_DATA_W-1:0] pinMode_r;
  // Flag pins 0-3 start in flag mode, all others in memory mode
  localparam logic [2*`EP_DATA_W-1:0] MODE_RESET = {{(`EP_DATA_W-`EP_FLAG_PINS){`EP_MODE_EXTERNAL_MEMORY_MODE}},
                                                     {`EP_FLAG_PINS{`EP_MODE_FLAG}}};
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pinMode_r <= MODE_RESET;
    else if (pinModeLoad)
      pinMode_r <= pinModeCfg;
  end

  // ****************************************
  // Access sequencer
  // ****************************************
  access_state_t state_r;
  access_state_t stateNxt;
  logic [7:0]    cnt_r;
  logic          write_r;
  logic [`EP_ADDR_W-1:0] addr_r;
  logic [`EP_DATA_W-1:0] wdata_r;

  wire strobeDone = (cnt_r == 8'(STROBE_CYC - 1));
  always_comb
  begin
    case (state_r)
      ST_IDLE:   stateNxt = accReq ? ST_STROBE : ST_IDLE;
      ST_STROBE: stateNxt = strobeDone ? ST_WAIT : ST_STROBE;
      ST_WAIT:   stateNxt = ackSync_r ? ST_DONE : ST_WAIT;
      ST_DONE:   stateNxt = ST_IDLE;
      default:   stateNxt = ST_IDLE;
    endcase
  end
  assign accReady = (state_r == ST_IDLE);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 8'h00;
      write_r <= 1'b0;
      addr_r  <= '0;
      wdata_r <= '0;
    end
    else
    begin
      state_r <= stateNxt;
      cnt_r   <= (state_r == ST_STROBE) ? cnt_r + 8'h01 : 8'h00;
      if (accReq && accReady)
      begin
        write_r <= accWrite;
        addr_r  <= accAddr;
        wdata_r <= accWdata;
      end
    end
  end

  wire active = (state_r == ST_STROBE) || (state_r == ST_WAIT);
  wire writeSel = (state_r == ST_IDLE) ? accWrite : write_r;
  // Strobes are registered so they never glitch on the pins
  logic rdN_r;
  logic wrN_r;
  logic done_r;
  logic [`EP_DATA_W-1:0] rdata_r;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdN_r   <= 1'b1;
      wrN_r   <= 1'b1;
      done_r  <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      rdN_r  <= !((stateNxt == ST_STROBE || stateNxt == ST_WAIT) && !writeSel);
      wrN_r  <= !((stateNxt == ST_STROBE || stateNxt == ST_WAIT) && writeSel);
      done_r <= (stateNxt == ST_DONE);
      if (state_r == ST_WAIT && ackSync_r && !write_r)
        rdata_r <= dataSync_r;
    end
  end
  assign readStrobeN  = rdN_r;
  assign writeStrobeN = wrN_r;
  assign accDone      = done_r;
  assign accRdata     = rdata_r;

  // ****************************************
  // Address, bank select, bit ten
  // ****************************************
  wire sdActive = sdCmdValid;
  logic [`EP_ADDR_W-1:0] addrOut_r;
  logic [`EP_BANKS-1:0]  bankN_r;
  logic                  tenLine_r;
  wire [`EP_ADDR_W-1:0]  addrSel = (state_r == ST_IDLE) ? accAddr : addr_r;
  wire bankBit = addrSel[`EP_BANK_LSB];
  wire bankHit = (addrSel[`EP_BANK_MSB] == 1'b0);
  wire [`EP_BANKS-1:0]   bankNxt = (accReq || active) && bankHit ? ~(2'h1 << bankBit) : 2'h3;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      addrOut_r <= '0;
      bankN_r   <= 2'h3;
      tenLine_r <= 1'b0;
    end
    else
    begin
      addrOut_r <= addrSel;
      bankN_r   <= (stateNxt == ST_IDLE) ? 2'h3 : bankNxt;
      tenLine_r <= sdActive ? sdTenValue : 1'b0;
    end
  end
  assign addrPins           = addrOut_r;
  assign bank_select_n      = bankN_r;
  assign sdram_bit_ten_line = tenLine_r;

  // ****************************************
  // Data pin sharing
  // ****************************************
  logic [`EP_DATA_W-1:0] dOut_r;
  logic [`EP_DATA_W-1:0] dOeN_r;
  logic [`EP_DATA_W-1:0] parallel_data_input_r;
  logic                  pdapV_r;
  logic [`EP_DATA_W-1:0] dOutNxt;
  logic [`EP_DATA_W-1:0] dOeNNxt;
  always_comb
  begin
    for (int i = 0; i < `EP_DATA_W; i++)
    begin
      case (modeOf(pinMode_r, i))
        `EP_MODE_EXTERNAL_MEMORY_MODE: begin dOutNxt[i] = wdata_r[i]; dOeNNxt[i] = !(active && write_r); end
        `EP_MODE_FLAG: begin dOutNxt[i] = flagOut[i]; dOeNNxt[i] = !flagOe[i]; end
        `EP_MODE_PWM:  begin dOutNxt[i] = pwmOut[i];  dOeNNxt[i] = 1'b0; end
        default:       begin dOutNxt[i] = 1'b0;       dOeNNxt[i] = 1'b1; end
      endcase
    end
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dOut_r  <= '0;
      dOeN_r  <= '1;
      parallel_data_input_r  <= '0;
      pdapV_r <= 1'b0;
    end
    else
    begin
      dOut_r  <= dOutNxt;
      dOeN_r  <= dOeNNxt;
      pdapV_r <= parallel_input_control;
      if (parallel_input_control)
        parallel_data_input_r <= dataSync_r;
    end
  end
  assign dataOut             = dOut_r;
  assign dataOeN             = dOeN_r;
  assign flagIn              = dataSync_r;
  assign parallel_data_input = parallel_data_input_r;
  assign parallelValid       = pdapV_r;

  // ****************************************
  // SDRAM command strobes
  // ****************************************
  ext_strobe_if cmdBus ();
  assign cmdBus.cmd      = sdCmd;
  assign cmdBus.cmdValid = sdCmdValid;
  sdram_cmd_encode u_enc
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .cmdBus  (cmdBus)
  );
  assign sdram_row_strobe_n    = cmdBus.rowStrobeN;
  assign sdram_column_strobe_n = cmdBus.colStrobeN;
  assign sdram_write_strobe_n  = cmdBus.wrStrobeN;

  // ****************************************
  // Checks
  // ****************************************
  ackHold_a: assert property (@(posedge sys_clk) disable iff (rst) (state_r == ST_WAIT && !ackSync_r) |=> !accDone)
    else $error("access completed while ack low");
  readLow_a: assert property (@(posedge sys_clk) disable iff (rst) (state_r == ST_WAIT && !write_r) |-> !readStrobeN)
    else $error("read strobe not low");
  writeLow_a: assert property (@(posedge sys_clk) disable iff (rst) (state_r == ST_WAIT && write_r) |-> !writeStrobeN)
    else $error("write strobe not low");
  idleHigh_a: assert property (@(posedge sys_clk) disable iff (rst) (state_r == ST_IDLE) |-> readStrobeN && writeStrobeN)
    else $error("strobe low while idle");
  addrOut_a: assert property (@(posedge sys_clk) disable iff (rst) (state_r == ST_WAIT) |-> addrPins == addr_r)
    else $error("address pins wrong");
  tenIdle_a: assert property (@(posedge sys_clk) disable iff (rst) !sdCmdValid |=> !sdram_bit_ten_line)
    else $error("bit ten line driven outside sdram");
  pdapCap_a: assert property (@(posedge sys_clk) disable iff (rst) parallel_input_control |=> parallel_data_input == $past(dataSync_r))
    else $error("parallel input not sampled");
  bankIdle_a: assert property (@(posedge sys_clk) disable iff (rst) (state_r == ST_IDLE && !accReq) |=> bank_select_n == 2'h3)
    else $error("bank select low while idle");
endmodule // ext_port_pins

// >>> design/ext_port_map.svh
`ifndef EXT_PORT_MAP_SVH
`define EXT_PORT_MAP_SVH
// Bus widths
`define EP_ADDR_W        24
`define EP_DATA_W        32
`define EP_BANKS         2
// Bank decode: address bits that pick the bank
`define EP_BANK_LSB      22
`define EP_BANK_MSB      23
`define EP_SDRAM_A10_BIT 10
// Dedicated flag pins on the data bus
`define EP_FLAG_PINS     4
// Default read/write strobe width in cycles before acknowledge is looked at
`define EP_STROBE_CYC    2
// Pin mode encodings, 2 bits per data pin
`define EP_MODE_EXTERNAL_MEMORY_MODE     2'h0
`define EP_MODE_FLAG     2'h1
`define EP_MODE_PWM      2'h2
`define EP_MODE_PARALLEL_DATA_INPUT     2'h3
// SDRAM command encodings {row, column, write}, active low
`define EP_CMD_NOP       3'h7
`define EP_CMD_ACT       3'h3
`define EP_CMD_READ      3'h5
`define EP_CMD_WRITE     3'h4
`define EP_CMD_PRE       3'h2
`define EP_CMD_REF       3'h1
`define EP_CMD_MRS       3'h0
`endif

// >>> design/ext_port_pkg.sv
package ext_port_pkg;
  typedef enum logic [2:0] {
    SD_NOP   = 3'h7,
    SD_ACT   = 3'h3,
    SD_READ  = 3'h5,
    SD_WRITE = 3'h4,
    SD_PRE   = 3'h2,
    SD_REF   = 3'h1,
    SD_MRS   = 3'h0
  } sdram_cmd_t;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_STROBE = 4'h2,
    ST_WAIT   = 4'h4,
    ST_DONE   = 4'h8
  } access_state_t;
endpackage

// >>> design/ext_strobe_if.sv
`timescale 1ns/1ns
interface ext_strobe_if;
  logic [2:0] cmd;
  logic       cmdValid;
  logic       rowStrobeN;
  logic       colStrobeN;
  logic       wrStrobeN;
  modport issuer (output cmd, output cmdValid);
  modport encoder (input cmd, input cmdValid, output rowStrobeN, output colStrobeN, output wrStrobeN);
endinterface

// >>> design/sdram_cmd_encode.sv
`timescale 1ns/1ns
`include "ext_port_map.svh"
module sdram_cmd_encode
(
  input wire logic     sys_clk,
  input wire logic     rst,
  ext_strobe_if.encoder cmdBus
);
  import ext_port_pkg::*;
  logic [2:0] pins_r;
  wire  [2:0] pinsNxt = cmdBus.cmdValid ? cmdBus.cmd : `EP_CMD_NOP;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pins_r <= `EP_CMD_NOP;
    else
      pins_r <= pinsNxt;
  end
  assign cmdBus.rowStrobeN = pins_r[2];
  assign cmdBus.colStrobeN = pins_r[1];
  assign cmdBus.wrStrobeN  = pins_r[0];
  idleNop_a: assert property (@(posedge sys_clk) disable iff (rst) !cmdBus.cmdValid |=> pins_r == 3'h7)
    else $error("sdram strobes not idle");
  cmdPins_a: assert property (@(posedge sys_clk) disable iff (rst) cmdBus.cmdValid |=> pins_r == $past(cmdBus.cmd))
    else $error("sdram command pins wrong");
endmodule // sdram_cmd_encode

// >>> sim/ext_mem_model.sv
`timescale 1ns/1ns
module ext_mem_model
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        readStrobeN,
  input  wire logic        writeStrobeN,
  input  wire logic [23:0] addrPins,
  input  wire logic [31:0] dataOut,
  input  wire logic [7:0]  waitCyc,
  input  wire logic        pdOn,
  input  wire logic [31:0] pdData,
  output logic             ackIn,
  output logic [31:0]      dataIn
);
  logic [31:0] mem [16];
  logic [31:0] last_r;
  logic [7:0]  cnt_r;
  wire         idle = readStrobeN & writeStrobeN;
  // Pulled high between accesses, low for waitCyc cycles of a strobe
  assign ackIn = idle | (cnt_r >= waitCyc);
  // Released bus shows the inverse of its last value, never a stale match
  assign dataIn = pdOn ? pdData : !readStrobeN ? mem[addrPins[3:0]] : ~last_r;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r  <= 8'h0;
      last_r <= 32'h0;
    end
    else
    begin
      cnt_r  <= idle ? 8'h0 : cnt_r + 8'h1;
      last_r <= dataIn;
      if (!writeStrobeN)
        mem[addrPins[3:0]] <= dataOut;
    end
  end
endmodule // ext_mem_model

// >>> sim/test_external_memory_port_pins.sv
`timescale 1ns/1ns
module test_external_memory_port_pins;
  import ext_port_pkg::*;
  logic sys_clk, rst = 1, accReq = 0, accWrite = 0, pinModeLoad = 0, pic = 0;
  logic sdCmdValid = 0, sdTenValue = 0, pdOn = 0, ackIn;
  logic accReady, accDone, parallelValid, readStrobeN, writeStrobeN, tenLine, rowN, colN, weN;
  logic [23:0] accAddr = 0, addrPins;
  logic [31:0] accWdata = 0, flagOut = 0, flagOe = 0, pdData = 0, dataIn;
  logic [31:0] accRdata, flagIn, pdIn, dataOut, dataOeN;
  logic [63:0] pinModeCfg = 0;
  logic [7:0]  waitCyc = 0;
  logic [1:0]  bankN;
  sdram_cmd_t  sdCmd = SD_NOP;
  int          n_mismatch = 0;
  int          tests_run = 0;
  ext_port_pins dut_u (.sys_clk(sys_clk), .rst(rst), .accReq(accReq), .accWrite(accWrite),
    .accAddr(accAddr), .accWdata(accWdata), .accReady(accReady), .accDone(accDone),
    .accRdata(accRdata), .sdCmd(sdCmd), .sdCmdValid(sdCmdValid), .sdTenValue(sdTenValue),
    .pinModeCfg(pinModeCfg), .pinModeLoad(pinModeLoad), .parallel_input_control(pic),
    .flagOut(flagOut), .flagOe(flagOe), .pwmOut(32'h0), .flagIn(flagIn),
    .parallel_data_input(pdIn), .parallelValid(parallelValid), .addrPins(addrPins),
    .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN), .ackIn(ackIn),
    .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .bank_select_n(bankN),
    .sdram_bit_ten_line(tenLine), .sdram_row_strobe_n(rowN), .sdram_column_strobe_n(colN),
    .sdram_write_strobe_n(weN));
  ext_mem_model mem_u (.sys_clk(sys_clk), .rst(rst), .readStrobeN(readStrobeN),
    .writeStrobeN(writeStrobeN), .addrPins(addrPins), .dataOut(dataOut), .waitCyc(waitCyc),
    .pdOn(pdOn), .pdData(pdData), .ackIn(ackIn), .dataIn(dataIn));
  initial
  begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic resetTest();
    repeat (5) @(posedge sys_clk);
    #1;
    chk("strobes", {readStrobeN, writeStrobeN, rowN, colN, weN}, 5'h1F);
    chk("idle oe", dataOeN, 32'hFFFFFFFF);
    chk("bank", bankN, 2'h3);
    chk("ready", accReady, 1'h1);
    $display("reset test done");
  endtask
  task automatic flagTest();
    @(posedge sys_clk);
    flagOe <= 32'hF;
    flagOut <= 32'h5;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("flag pins", {dataOeN[3:0], dataOut[3:0]}, 8'h05);
    chk("mem pins", dataOeN[31:4], 28'hFFFFFFF);
    @(posedge sys_clk);
    flagOe <= 32'h0;
    pinModeCfg <= 64'h0;
    pinModeLoad <= 1;
    @(posedge sys_clk);
    pinModeLoad <= 0;
    $display("flag test done");
  endtask
  // Cheaper to check the pins at strobe time than to track them every cycle
  task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d, input logic [7:0] wc);
    int n;
    @(posedge sys_clk);
    accReq <= 1;
    accWrite <= w;
    accAddr <= a;
    accWdata <= d;
    waitCyc <= wc;
    @(posedge sys_clk);
    accReq <= 0;
    @(posedge sys_clk);
    #1;
    chk("strobe", w ? writeStrobeN : readStrobeN, 1'h0);
    chk("other", w ? readStrobeN : writeStrobeN, 1'h1);
    chk("addr", addrPins, a);
    chk("bank", bankN, a[23] ? 2'h3 : 2'(~(2'h1 << a[22])));
    if (w)
      chk("wdata", {dataOeN ^ dataOut}, d);
    n = 0;
    while (accDone !== 1'b1 && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 200)
    begin
      n_mismatch++;
      summarize();
    end
    chk("held", n >= wc + 2, 1'h1);
    chk("released", {readStrobeN, writeStrobeN}, 2'h3);
    if (!w)
      chk("rdata", accRdata, d);
  endtask
  task automatic sdramTest();
    sdram_cmd_t cl [7] = '{SD_NOP, SD_ACT, SD_READ, SD_WRITE, SD_PRE, SD_REF, SD_MRS};
    for (int i = 0; i < 7; i++)
    begin
      @(posedge sys_clk);
      sdCmd <= cl[i];
      sdCmdValid <= 1;
      sdTenValue <= i[0];
      @(posedge sys_clk);
      #1;
      chk("cmd", {rowN, colN, weN}, cl[i]);
      chk("bit ten", tenLine, i[0]);
    end
    @(posedge sys_clk);
    sdCmdValid <= 0;
    @(posedge sys_clk);
    #1;
    chk("cmd idle", {rowN, colN, weN}, 3'h7);
    $display("sdram test done");
  endtask
  task automatic parallelTest();
    @(posedge sys_clk);
    pinModeCfg <= {32{2'h3}};
    pinModeLoad <= 1;
    pic <= 1;
    pdOn <= 1;
    pdData <= 32'hC3A55A3C;
    @(posedge sys_clk);
    pinModeLoad <= 0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("pdata", pdIn, 32'hC3A55A3C);
    chk("pvalid", parallelValid, 1'h1);
    chk("pins in", dataOeN, 32'hFFFFFFFF);
    chk("flag in", flagIn, 32'hC3A55A3C);
    $display("parallel test done");
  endtask
  initial
  begin
    resetTest();
    repeat (5) @(posedge sys_clk);
    rst <= 0;
    flagTest();
    acc(1, 24'h000405, 32'hA5A50F0F, 5);
    acc(1, 24'h400007, 32'h12345678, 0);
    acc(0, 24'h000405, 32'hA5A50F0F, 3);
    acc(0, 24'h800007, 32'h12345678, 0);
    $display("access test done");
    sdramTest();
    parallelTest();
    summarize();
  end
endmodule // test_external_memory_port_pins
